// ==== dv/cirsc_card_model.sv ====
`timescale 1ns/1ps

module cirsc_card_model
(
   input  wire  card_reset_i,
   output logic cd_a_n_o,
   output logic cd_b_n_o,
   output logic ready_o,
   output logic bvd_a_o,
   output logic bvd_b_o,
   output logic ireq_n_o
);
   logic ready_r = 1'b0;

   initial
   begin
      cd_a_n_o = 1'b0;
      cd_b_n_o = 1'b0;
      bvd_a_o  = 1'b1;
      bvd_b_o  = 1'b1;
      ireq_n_o = 1'b0;
   end

   // A card held in reset never reports ready
   assign ready_o = ready_r & ~card_reset_i;
endmodule // cirsc_card_model

// ==== dv/cirsc_chk.sv ====
`timescale 1ns/1ps
`include "cirsc_consts.vh"

module cirsc_chk
(
   input wire                     SYS_CLK_I,
   input wire                     RESET_N_I,
   input wire [`CIRSC_ADDR_W-1:0] REG_ADDR_I,
   input wire                     REG_WR_I,
   input wire                     REG_RD_I,
   input wire [7:0]               REG_WDATA_I,
   input wire [7:0]               REG_RDATA_O,
   input wire [7:0]               STATUS_CFG_I,
   input wire                     SIXTEEN_BIT_CARD_I,
   input wire                     CARD_RESET_O,
   input wire                     RING_INDICATE_ENABLE_O,
   input wire                     INSTALLED_CARD_KIND_O,
   input wire [15:0]              FUNC_IRQ_O,
   input wire                     FUNC_SMI_O,
   input wire                     STATUS_PCI_IRQ_O,
   input wire [15:0]              STATUS_IRQ_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);

   wire wr_ctrl = REG_WR_I && REG_ADDR_I == `CIRSC_CTRL_OFS;
   wire rd_flag = REG_RD_I && REG_ADDR_I == `CIRSC_FLAG_OFS;
   wire wd_run  = REG_WDATA_I[`CIRSC_CARD_RUN_BIT];

   ring_write_a: assert property (wr_ctrl |=>
      RING_INDICATE_ENABLE_O == $past(REG_WDATA_I[7])) else $error("ring enable not stored");
   kind_write_a: assert property (wr_ctrl |=>
      INSTALLED_CARD_KIND_O == $past(REG_WDATA_I[5])) else $error("card kind not stored");
   card_reset_a: assert property (wr_ctrl |=> ##1
      CARD_RESET_O == ($past(SIXTEEN_BIT_CARD_I) & ~$past(wd_run, 2)))
      else $error("card reset level wrong");
   upper_zero_a: assert property (rd_flag |=> REG_RDATA_O[7:4] == 4'h0)
      else $error("upper read bits not zero");
   func_line_a: assert property ($onehot0(FUNC_IRQ_O) && !FUNC_IRQ_O[0] && !FUNC_IRQ_O[2])
      else $error("functional line select broken");
   func_smi_a: assert property ($rose(FUNC_SMI_O) |-> INSTALLED_CARD_KIND_O)
      else $error("smi without io card");
   pci_only_a: assert property (STATUS_PCI_IRQ_O |-> STATUS_IRQ_O == 16'h0000)
      else $error("status on pci and line");
   disabled_zero_a: assert property (rd_flag && $stable(STATUS_CFG_I)
      && STATUS_CFG_I[3:0] == 4'h0 |=> REG_RDATA_O == 8'h00) else $error("disabled flag set");
   io_zero_a: assert property (rd_flag && INSTALLED_CARD_KIND_O |=>
      REG_RDATA_O[2:1] == 2'b00) else $error("memory flags on io card");
endmodule // cirsc_chk

bind cirsc_regs cirsc_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
   .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .STATUS_CFG_I(STATUS_CFG_I),
   .SIXTEEN_BIT_CARD_I(SIXTEEN_BIT_CARD_I), .CARD_RESET_O(CARD_RESET_O),
   .RING_INDICATE_ENABLE_O(RING_INDICATE_ENABLE_O),
   .INSTALLED_CARD_KIND_O(INSTALLED_CARD_KIND_O), .FUNC_IRQ_O(FUNC_IRQ_O),
   .FUNC_SMI_O(FUNC_SMI_O), .STATUS_PCI_IRQ_O(STATUS_PCI_IRQ_O),
   .STATUS_IRQ_O(STATUS_IRQ_O));

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
   logic        clk = 0, rst_n = 0, wr = 0, rd = 0, cbw = 0, sbc = 1;
   logic [11:0] addr = 0;
   logic [7:0]  wd = 0, cfg = 0;
   wire  [7:0]  rdata;
   wire  [15:0] firq, sirq;
   wire         cres, ring, kind, fsmi, spci, ssmi, cda, cdb, rdy, bva, bvb, irq;
   int          n_fail = 0, n_compared = 0;

   always #5 clk = ~clk;

   cirsc_regs u_dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr),
      .REG_RD_I(rd), .REG_WDATA_I(wd), .REG_RDATA_O(rdata), .STATUS_CFG_I(cfg),
      .CLEAR_BY_WRITE_I(cbw), .SIXTEEN_BIT_CARD_I(sbc), .CARD_DETECT_A_N_I(cda),
      .CARD_DETECT_B_N_I(cdb), .CARD_READY_I(rdy), .BATTERY_DETECT_RING_PIN_I(bva),
      .BATTERY_DETECT_B_I(bvb), .CARD_IREQ_N_I(irq), .CARD_RESET_O(cres),
      .RING_INDICATE_ENABLE_O(ring), .INSTALLED_CARD_KIND_O(kind), .FUNC_IRQ_O(firq),
      .FUNC_SMI_O(fsmi), .STATUS_PCI_IRQ_O(spci), .STATUS_IRQ_O(sirq), .STATUS_SMI_O(ssmi));

   cirsc_card_model u_card (.card_reset_i(cres), .cd_a_n_o(cda), .cd_b_n_o(cdb),
      .ready_o(rdy), .bvd_a_o(bva), .bvd_b_o(bvb), .ireq_n_o(irq));

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task wr_reg(input logic [11:0] a, input logic [7:0] d);
      addr = a;
      wd   = d;
      wr   = 1;
      cyc(1);
      wr   = 0;
      // Idle cycle so a following write never re-raises the strobe in one step
      cyc(1);
   endtask

   task rd_reg(input logic [11:0] a, input logic [7:0] e);
      addr = a;
      rd   = 1;
      cyc(1);
      rd   = 0;
      chk("read data", {8'h00, e}, {8'h00, rdata});
      cyc(1);
   endtask

   task t_reset;
      rd_reg(12'h803, 8'h00);
      rd_reg(12'h804, 8'h00);
      rd_reg(12'h805, 8'h00);
      chk("card reset", 16'h1, {15'h0, cres});
      // A 32-bit card ignores the reset bit
      sbc = 0;
      cyc(2);
      chk("card reset", 16'h0, {15'h0, cres});
      sbc = 1;
      cyc(2);
   endtask

   task t_route;
      for (int n = 0; n < 16; n++)
      begin
         wr_reg(12'h803, 8'h60 | n[7:0]);
         cyc(6);
         chk("func irq", (n == 0 || n == 2) ? 16'h0 : 16'h1 << n, firq);
         chk("func smi", {15'h0, n == 2}, {15'h0, fsmi});
         chk("card reset", 16'h0, {15'h0, cres});
         rd_reg(12'h803, 8'h60 | n[7:0]);
      end
   endtask

   task t_ready;
      cfg = 8'h54;
      wr_reg(12'h803, 8'h41);
      u_card.ready_r = 1;
      cyc(6);
      chk("status line", 16'h0020, sirq);
      chk("status pci", 16'h0, {15'h0, spci});
      rd_reg(12'h804, 8'h04);
      rd_reg(12'h804, 8'h00);
      chk("status line", 16'h0, sirq);
      // Status select code 2 goes to SMI
      u_card.ready_r = 0;
      cfg = 8'h24;
      cyc(6);
      u_card.ready_r = 1;
      cyc(6);
      chk("status smi", 16'h1, {15'h0, ssmi});
      chk("status line", 16'h0, sirq);
      rd_reg(12'h804, 8'h04);
      cyc(2);
      chk("status smi", 16'h0, {15'h0, ssmi});
   endtask

   task t_detect;
      cbw = 1;
      cfg = 8'h58;
      wr_reg(12'h803, 8'h51);
      u_card.cd_a_n_o = 1;
      cyc(6);
      chk("status pci", 16'h1, {15'h0, spci});
      chk("status line", 16'h0, sirq);
      wr_reg(12'h804, 8'h00);
      rd_reg(12'h804, 8'h08);
      rd_reg(12'h804, 8'h08);
      wr_reg(12'h804, 8'h08);
      rd_reg(12'h804, 8'h00);
   endtask

   task t_battery;
      cbw = 0;
      cfg = 8'h03;
      wr_reg(12'h803, 8'h40);
      u_card.bvd_a_o = 0;
      cyc(6);
      chk("status pci", 16'h1, {15'h0, spci});
      rd_reg(12'h804, 8'h02);
      u_card.bvd_b_o = 0;
      cyc(6);
      rd_reg(12'h804, 8'h01);
      wr_reg(12'h803, 8'h60);
      u_card.bvd_b_o = 1;
      cyc(6);
      rd_reg(12'h804, 8'h00);
      u_card.bvd_a_o = 1;
      cyc(6);
      rd_reg(12'h804, 8'h01);
      wr_reg(12'h803, 8'he0);
      cyc(6);
      rd_reg(12'h804, 8'h01);
      rd_reg(12'h804, 8'h01);
      u_card.bvd_a_o = 0;
      cyc(6);
      rd_reg(12'h804, 8'h00);
   endtask

   task t_disabled;
      cfg = 8'h00;
      u_card.cd_b_n_o = 1;
      cyc(6);
      rd_reg(12'h804, 8'h00);
   endtask

   task test_done;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1;
      // Pin edges are ignored while the synchronizers fill
      cyc(4);
      t_reset();
      t_route();
      t_ready();
      t_detect();
      t_battery();
      t_disabled();
      test_done();
   end

   initial
   begin
      #100us;
      n_fail++;
      test_done();
   end
endmodule // tb_top

// ==== hw/cirsc_consts.vh ====
`ifndef CIRSC_CONSTS_VH
`define CIRSC_CONSTS_VH

// Register offsets from the socket base
`define CIRSC_ADDR_W        12
`define CIRSC_CTRL_OFS      12'h803
`define CIRSC_FLAG_OFS      12'h804

// Reset values
`define CIRSC_CTRL_RST      8'h00
`define CIRSC_FLAG_RST      4'h0
`define CIRSC_RDATA_RST     8'h00

// Interrupt and general control register fields
`define CIRSC_RING_EN_BIT   7
`define CIRSC_CARD_RUN_BIT  6
`define CIRSC_KIND_BIT      5
`define CIRSC_TO_PCI_BIT    4
`define CIRSC_FSEL_HI       3
`define CIRSC_FSEL_LO       0

// Status-change configuration input fields
`define CIRSC_SSEL_HI       7
`define CIRSC_SSEL_LO       4

// Flag and enable bit positions (shared layout)
`define CIRSC_DET_BIT       3
`define CIRSC_READY_BIT     2
`define CIRSC_WARN_BIT      1
`define CIRSC_DEAD_BIT      0

// Line select codes
`define CIRSC_SEL_NONE      4'h0
`define CIRSC_SEL_SMI       4'h2

// Battery detect decode, {second, first}
`define CIRSC_BAT_WARN      2'b10
`define CIRSC_BAT_GOOD      2'b11

// Cycles after reset before pin edges are trusted
`define CIRSC_WARM_CYCLES   2'h3

`endif

// ==== hw/cirsc_regs.v ====
// Summary of operation
// - Control register at 803h, resets zero
// - Bit 7 enables ring indicate function
// - Bit 6 releases 16-bit card reset
// - Bit 5 selects memory or I/O card
// - Bit 4 sends status interrupts to PCI
// - Bits 3-0 pick functional line, 2=SMI
// - Select zero also routes status to PCI
// - Flag register at 804h, upper nibble zero
// - Disabled sources always read as zero
// - Enabled active source sets flag, interrupts
// - Clear by read or write-one, mode selected
// - Bit 3 sets on card-detect change
// - Bit 2 sets on READY rise, memory
// - Bit 1 sets on battery warning, memory
// - Bit 0 battery dead or status change
// - Ring enabled: bit 0 shows ring input
// - Battery detect decode: dead, warning, good
// - Separate enable per status-change source
// - Status line select from config bits 7-4
`timescale 1ns/1ps
`include "cirsc_consts.vh"

module cirsc_regs
(
   input  wire                     SYS_CLK_I,
   input  wire                     RESET_N_I,
   input  wire [`CIRSC_ADDR_W-1:0] REG_ADDR_I,
   input  wire                     REG_WR_I,
   input  wire                     REG_RD_I,
   input  wire [7:0]               REG_WDATA_I,
   output wire [7:0]               REG_RDATA_O,
   input  wire [7:0]               STATUS_CFG_I,
   input  wire                     CLEAR_BY_WRITE_I,
   input  wire                     SIXTEEN_BIT_CARD_I,
   input  wire                     CARD_DETECT_A_N_I,
   input  wire                     CARD_DETECT_B_N_I,
   input  wire                     CARD_READY_I,
   input  wire                     BATTERY_DETECT_RING_PIN_I,
   input  wire                     BATTERY_DETECT_B_I,
   input  wire                     CARD_IREQ_N_I,
   output wire                     CARD_RESET_O,
   output wire                     RING_INDICATE_ENABLE_O,
   output wire                     INSTALLED_CARD_KIND_O,
   output wire [15:0]              FUNC_IRQ_O,
   output wire                     FUNC_SMI_O,
   output wire                     STATUS_PCI_IRQ_O,
   output wire [15:0]              STATUS_IRQ_O,
   output wire                     STATUS_SMI_O
);

   // Decode a 4-bit line select: code 0 drives nothing, code 2 drives SMI, any other code n drives IRQ n
   function [16:0] route_decode;
      input [3:0] code;
      input       act;
      begin
         route_decode = 17'h00000;
         if (act && (code == `CIRSC_SEL_SMI))
            route_decode[16] = 1'b1;
         else if (act && (code != `CIRSC_SEL_NONE))
            route_decode[15:0] = 16'h0001 << code;
      end
   endfunction

   // Pin synchronizers
   wire [5:0] pin_raw;
   wire [5:0] pin_s;

   assign pin_raw = {CARD_IREQ_N_I, BATTERY_DETECT_B_I, BATTERY_DETECT_RING_PIN_I,
                     CARD_READY_I, CARD_DETECT_B_N_I, CARD_DETECT_A_N_I};

   cirsc_sync
   #(
      .W (6)
   )
   u_pin_sync
   (
      .sys_clk_i (SYS_CLK_I),
      .reset_n_i (RESET_N_I),
      .async_i   (pin_raw),
      .sync_o    (pin_s)
   );

   wire card_detect_a;
   wire card_detect_b;
   wire card_ready;
   wire battery_detect_ring_pin;
   wire battery_detect_b;
   wire card_ireq_n;

   assign card_detect_a           = pin_s[0];
   assign card_detect_b           = pin_s[1];
   assign card_ready              = pin_s[2];
   assign battery_detect_ring_pin = pin_s[3];
   assign battery_detect_b        = pin_s[4];
   assign card_ireq_n             = pin_s[5];

   // State
   reg [7:0]  ctrl_r;
   reg [3:0]  flag_r;
   reg [7:0]  rdata_r;
   reg [4:0]  prev_r;
   reg [1:0]  warm_r;
   reg        card_reset_r;
   reg [15:0] func_irq_r;
   reg        func_smi_r;
   reg        status_pci_r;
   reg [15:0] status_irq_r;
   reg        status_smi_r;

   // Control fields
   wire       ring_indicate_enable;
   wire       installed_card_kind;
   wire       status_change_to_pci;
   wire [3:0] functional_irq_line_select;
   wire [3:0] status_change_line_select;
   wire       memory_card;

   assign ring_indicate_enable       = ctrl_r[`CIRSC_RING_EN_BIT];
   assign installed_card_kind        = ctrl_r[`CIRSC_KIND_BIT];
   assign status_change_to_pci       = ctrl_r[`CIRSC_TO_PCI_BIT];
   assign functional_irq_line_select = ctrl_r[`CIRSC_FSEL_HI:`CIRSC_FSEL_LO];
   assign status_change_line_select  = STATUS_CFG_I[`CIRSC_SSEL_HI:`CIRSC_SSEL_LO];
   assign memory_card                = ~installed_card_kind;

   wire detect_change_enable;
   wire ready_rise_enable;
   wire battery_warning_enable;
   wire battery_dead_enable;

   assign detect_change_enable   = STATUS_CFG_I[`CIRSC_DET_BIT];
   assign ready_rise_enable      = STATUS_CFG_I[`CIRSC_READY_BIT];
   assign battery_warning_enable = STATUS_CFG_I[`CIRSC_WARN_BIT];
   assign battery_dead_enable    = STATUS_CFG_I[`CIRSC_DEAD_BIT];

   // Edges are ignored until the synchronizers hold real pin levels,
   // otherwise the reset zeros would look like a card insertion
   wire warm;
   assign warm = (warm_r == `CIRSC_WARM_CYCLES);

   wire [1:0] bat_code;
   wire       warn_now;
   wire       dead_now;
   wire       warn_prev;
   wire       dead_prev;

   assign bat_code  = {battery_detect_b, battery_detect_ring_pin};
   assign warn_now  = (bat_code == `CIRSC_BAT_WARN);
   assign dead_now  = ~bat_code[1];
   assign warn_prev = (prev_r[4:3] == `CIRSC_BAT_WARN);
   assign dead_prev = ~prev_r[4];

   // Source events
   wire det_evt;
   wire ready_evt;
   wire warn_evt;
   wire dead_evt;
   wire stat_evt;

   assign det_evt   = warm & ((card_detect_a ^ prev_r[0]) | (card_detect_b ^ prev_r[1]));
   assign ready_evt = warm & card_ready & ~prev_r[2];
   assign warn_evt  = warm & warn_now & ~warn_prev;
   assign dead_evt  = warm & dead_now & ~dead_prev;
   assign stat_evt  = warm & battery_detect_ring_pin & ~prev_r[3];

   reg [3:0] set_v;
   always @*
   begin
      set_v = 4'h0;
      set_v[`CIRSC_DET_BIT]   = det_evt & detect_change_enable;
      set_v[`CIRSC_READY_BIT] = ready_evt & memory_card & ready_rise_enable;
      set_v[`CIRSC_WARN_BIT]  = warn_evt & memory_card & battery_warning_enable;
      // dead on memory, status change on I/O
      set_v[`CIRSC_DEAD_BIT]  = battery_dead_enable & ~ring_indicate_enable &
                                (memory_card ? dead_evt : stat_evt);
   end

   wire [3:0] keep_mask;
   assign keep_mask = {detect_change_enable, ready_rise_enable & memory_card,
                       battery_warning_enable & memory_card,
                       battery_dead_enable & ~ring_indicate_enable};

   // Visible flag value
   reg [3:0] vis_flags;
   always @*
   begin
      vis_flags = flag_r & keep_mask;
      if (ring_indicate_enable)
         vis_flags[`CIRSC_DEAD_BIT] = battery_dead_enable & battery_detect_ring_pin & warm;
   end

   // Register access decode
   wire ctrl_hit;
   wire flag_hit;
   assign ctrl_hit = (REG_ADDR_I == `CIRSC_CTRL_OFS);
   assign flag_hit = (REG_ADDR_I == `CIRSC_FLAG_OFS);

   reg [3:0] clr_v;
   always @*
   begin
      clr_v = 4'h0;
      if (!CLEAR_BY_WRITE_I && REG_RD_I && flag_hit)
         clr_v = 4'hf;
      else if (CLEAR_BY_WRITE_I && REG_WR_I && flag_hit)
         clr_v = REG_WDATA_I[3:0];
   end

   wire [3:0] flag_nxt;
   assign flag_nxt = ((flag_r & ~clr_v) & keep_mask) | set_v;

   reg [7:0] rdata_nxt;
   always @*
   begin
      rdata_nxt = rdata_r;
      if (REG_RD_I)
      begin
         if (ctrl_hit)
            rdata_nxt = ctrl_r;
         else if (flag_hit)
            rdata_nxt = {4'h0, vis_flags};
         else
            rdata_nxt = `CIRSC_RDATA_RST;
      end
   end

   // Routing
   wire        pending;
   wire        to_pci;
   wire [16:0] status_route;
   wire [16:0] func_route;
   wire        func_active;

   assign pending = |vis_flags;
   // PCI route, select zero ORed in
   assign to_pci = status_change_to_pci | (functional_irq_line_select == `CIRSC_SEL_NONE);
   assign status_route = route_decode(status_change_line_select, pending & ~to_pci);
   // Functional interrupt only exists for I/O cards
   assign func_active = warm & installed_card_kind & ~card_ireq_n;
   assign func_route = route_decode(functional_irq_line_select, func_active);

   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         ctrl_r       <= `CIRSC_CTRL_RST;
         flag_r       <= `CIRSC_FLAG_RST;
         rdata_r      <= `CIRSC_RDATA_RST;
         prev_r       <= 5'h00;
         warm_r       <= 2'h0;
         card_reset_r <= 1'b0;
         func_irq_r   <= 16'h0000;
         func_smi_r   <= 1'b0;
         status_pci_r <= 1'b0;
         status_irq_r <= 16'h0000;
         status_smi_r <= 1'b0;
      end
      else
      begin
         if (REG_WR_I && ctrl_hit)
            ctrl_r <= REG_WDATA_I;
         flag_r  <= flag_nxt;
         rdata_r <= rdata_nxt;
         prev_r  <= {battery_detect_b, battery_detect_ring_pin, card_ready,
                     card_detect_b, card_detect_a};
         if (!warm)
            warm_r <= warm_r + 2'h1;
         // reset held while bit clear, 16-bit only
         card_reset_r <= SIXTEEN_BIT_CARD_I & ~ctrl_r[`CIRSC_CARD_RUN_BIT];
         func_irq_r   <= func_route[15:0];
         func_smi_r   <= func_route[16];
         status_pci_r <= pending & to_pci;
         status_irq_r <= status_route[15:0];
         status_smi_r <= status_route[16];
      end
   end

   assign REG_RDATA_O            = rdata_r;
   assign CARD_RESET_O           = card_reset_r;
   assign RING_INDICATE_ENABLE_O = ctrl_r[`CIRSC_RING_EN_BIT];
   assign INSTALLED_CARD_KIND_O  = ctrl_r[`CIRSC_KIND_BIT];
   assign FUNC_IRQ_O             = func_irq_r;
   assign FUNC_SMI_O             = func_smi_r;
   assign STATUS_PCI_IRQ_O       = status_pci_r;
   assign STATUS_IRQ_O           = status_irq_r;
   assign STATUS_SMI_O           = status_smi_r;

endmodule // cirsc_regs

// ==== hw/cirsc_sync.v ====
`timescale 1ns/1ps

module cirsc_sync
#(
   parameter W = 1
)
(
   input  wire         sys_clk_i,
   input  wire         reset_n_i,
   input  wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   // Two stages; only the second stage is visible outside
   always @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end
      else
      begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end

   assign sync_o = sync_r;

endmodule // cirsc_sync
